// ==== design/mmc_mask_cfg.sv ====
// Multicast mask edit port: an AHB-Lite slave holding one register that edits and
// queries a table of multicast masks, each a set of egress ports.
// Assumes the single slave's hreadyout is fed back as hready; one clock, sync reset.
//
// Operation
// - Three-bit mask index selects which mask is edited or queried.
// - Four-bit egress port field names the one port added or removed.
// - Add-all and delete-all commands ignore the egress port field.
// - Query setup command records index and port only; no mask changes.
// - Add command sets the named port bit in the selected mask only.
// - Delete command clears the named port bit in the selected mask only.
// - Delete-all command empties the selected mask.
// - Add-all command sets every port bit of the selected mask.
// - Read-only flag shows membership of last queried port in queried mask.
// - Command, index and port fields read back their last written values.
// - Edits are taken whether or not the mask is bound to an ID.
// - Masks drive replication only after a separate binding step elsewhere.
`timescale 1ns/1ps
module mmc_mask_cfg
   import mmc_pkg::*;
#(
   parameter int NUM_MASKS = 8,
   parameter int NUM_PORTS = 16
) (
   input  wire  logic                                  clk,       // Register clock, 125 MHz.
   input  wire  logic                                  rst,       // Synchronous reset, active high.
   input  wire  logic                                  hsel,      // Slave select.
   input  wire  logic [31:0]                           haddr,     // Byte address.
   input  wire  logic [1:0]                            htrans,    // Transfer type.
   input  wire  logic                                  hwrite,    // Write when high.
   input  wire  logic [2:0]                            hsize,     // Transfer size.
   input  wire  logic [31:0]                           hwdata,    // Write data.
   input  wire  logic                                  hready,    // Bus ready.
   output logic       [31:0]                           hrdata,    // Read data.
   output logic                                        hreadyout, // Slave ready.
   output logic                                        hresp,     // Response, always OKAY.
   output logic       [NUM_MASKS-1:0][NUM_PORTS-1:0]   maskTable  // Mask contents for the group table.
);
   import mmc_pkg::*;

   // ------------------------------------------------------------
   // Address phase capture
   // ------------------------------------------------------------
   mmc_aphase_t aphFf;
   mmc_aphase_t nxt_aph;
   logic        take;

   always_comb begin
      take    = hsel && hready && (htrans == MMC_HTRANS_NONSEQ);
      nxt_aph = MMC_APHASE_IDLE;
      if (take) begin
         nxt_aph.wr  = hwrite;
         nxt_aph.rd  = !hwrite;
         nxt_aph.hit = (haddr[31:2] == MMC_EDIT_OFFSET[31:2]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aphFf <= MMC_APHASE_IDLE;
      end else begin
         aphFf <= nxt_aph;
      end
   end

   // ------------------------------------------------------------
   // Edit register and mask table
   // ------------------------------------------------------------
   logic [MMC_MASK_W-1:0]               maskIdxFf, nxt_maskIdx;
   logic [MMC_PORT_W-1:0]               portIdxFf, nxt_portIdx;
   logic [MMC_CMD_W-1:0]                cmdFf,     nxt_cmd;
   logic [MMC_MASK_W-1:0]               qMaskFf,   nxt_qMask;
   logic [MMC_PORT_W-1:0]               qPortFf,   nxt_qPort;
   logic [NUM_MASKS-1:0][NUM_PORTS-1:0] maskFf,    nxt_mask;
   logic                                wrEn;
   logic [MMC_MASK_W-1:0]               wIdx;
   logic [MMC_PORT_W-1:0]               wPort;
   logic [MMC_CMD_W-1:0]                wCmd;

   // An unmapped write is dropped here; it still completes OKAY on the bus.
   always_comb begin
      wrEn        = aphFf.wr && aphFf.hit;
      wIdx        = hwdata[MMC_MASK_LSB +: MMC_MASK_W];
      wPort       = hwdata[MMC_PORT_LSB +: MMC_PORT_W];
      wCmd        = hwdata[MMC_CMD_LSB  +: MMC_CMD_W];
      nxt_maskIdx = maskIdxFf;
      nxt_portIdx = portIdxFf;
      nxt_cmd     = cmdFf;
      nxt_qMask   = qMaskFf;
      nxt_qPort   = qPortFf;
      nxt_mask    = maskFf;
      // No binding state gates the edit: bound masks change in place.
      if (wrEn) begin
         nxt_maskIdx = wIdx;
         nxt_portIdx = wPort;
         nxt_cmd     = wCmd;
         case (wCmd)
            MMC_CMD_QUERY: begin
               nxt_qMask = wIdx;
               nxt_qPort = wPort;
            end
            MMC_CMD_ADD: begin
               nxt_mask[wIdx][wPort] = 1'h1;
            end
            MMC_CMD_DEL: begin
               nxt_mask[wIdx][wPort] = 1'h0;
            end
            MMC_CMD_CLR_ALL: begin
               nxt_mask[wIdx] = '0;
            end
            MMC_CMD_SET_ALL: begin
               nxt_mask[wIdx] = '1;
            end
            default: begin
               nxt_mask = maskFf;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         maskIdxFf <= MMC_EDIT_RESET[MMC_MASK_LSB +: MMC_MASK_W];
         portIdxFf <= MMC_EDIT_RESET[MMC_PORT_LSB +: MMC_PORT_W];
         cmdFf     <= MMC_EDIT_RESET[MMC_CMD_LSB  +: MMC_CMD_W];
         qMaskFf   <= MMC_EDIT_RESET[MMC_MASK_LSB +: MMC_MASK_W];
         qPortFf   <= MMC_EDIT_RESET[MMC_PORT_LSB +: MMC_PORT_W];
         maskFf    <= '0;
      end else begin
         maskIdxFf <= nxt_maskIdx;
         portIdxFf <= nxt_portIdx;
         cmdFf     <= nxt_cmd;
         qMaskFf   <= nxt_qMask;
         qPortFf   <= nxt_qPort;
         maskFf    <= nxt_mask;
      end
   end

   // ------------------------------------------------------------
   // Read path and outputs
   // ------------------------------------------------------------
   logic [31:0] readWord;

   // The flag follows the live table, so a later edit to the queried mask shows at once.
   always_comb begin
      readWord                                = MMC_EDIT_RESET;
      readWord[MMC_MASK_LSB +: MMC_MASK_W]    = maskIdxFf;
      readWord[MMC_PORT_LSB +: MMC_PORT_W]    = portIdxFf;
      readWord[MMC_CMD_LSB  +: MMC_CMD_W]     = cmdFf;
      readWord[MMC_FLAG_BIT]                  = maskFf[qMaskFf][qPortFf];
      hrdata    = (aphFf.rd && aphFf.hit) ? readWord : 32'h0000_0000;
      hreadyout = 1'h1;
      hresp     = MMC_HRESP_OKAY;
      maskTable = maskFf;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_write(logic [MMC_CMD_W-1:0] c);
      wrEn && (wCmd == c);
   endsequence

   sequence s_readBack;
      aphFf.rd && aphFf.hit;
   endsequence

   chk_add_sets_bit: assert property (s_write(MMC_CMD_ADD) |=> maskFf[maskIdxFf][portIdxFf])
      else $error("Add command did not set the port bit.");
   chk_add_one_bit: assert property (s_write(MMC_CMD_ADD) |=> $countones(maskFf ^ $past(maskFf)) <= 1)
      else $error("Add command changed more than one bit.");
   chk_del_clears_bit: assert property (s_write(MMC_CMD_DEL) |=> !maskFf[maskIdxFf][portIdxFf])
      else $error("Delete command did not clear the port bit.");
   chk_del_one_bit: assert property (s_write(MMC_CMD_DEL) |=> $countones(maskFf ^ $past(maskFf)) <= 1)
      else $error("Delete command changed more than one bit.");
   chk_clr_all_empty: assert property (s_write(MMC_CMD_CLR_ALL) |=> maskFf[maskIdxFf] == '0)
      else $error("Delete-all left a port in the mask.");
   chk_set_all_full: assert property (s_write(MMC_CMD_SET_ALL) |=> &maskFf[maskIdxFf])
      else $error("Add-all left a port out of the mask.");
   chk_query_no_edit: assert property (s_write(MMC_CMD_QUERY) |=> maskFf == $past(maskFf))
      else $error("Query setup changed a mask.");
   chk_reserved_no_edit: assert property (wrEn && (wCmd == 3'h3 || wCmd > 3'h5) |=> $stable(maskFf))
      else $error("Reserved command changed a mask.");
   // A single-transfer master reads three edges after a write: two quiet edges, then the read data phase.
   sequence s_gapThenRead;
      !wrEn ##1 !wrEn ##1 s_readBack;
   endsequence

   chk_query_flag: assert property (s_write(MMC_CMD_QUERY) ##1 s_gapThenRead
         |-> hrdata[MMC_FLAG_BIT] == maskFf[$past(wIdx, 3)][$past(wPort, 3)])
      else $error("Membership flag does not match the queried mask.");
   chk_field_readback: assert property (wrEn ##1 s_gapThenRead
         |-> hrdata[MMC_CMD_LSB +: MMC_CMD_W] == $past(wCmd, 3)
             && hrdata[MMC_MASK_LSB +: MMC_MASK_W] == $past(wIdx, 3)
             && hrdata[MMC_PORT_LSB +: MMC_PORT_W] == $past(wPort, 3))
      else $error("Written fields do not read back.");
   chk_bus_okay: assert property (hreadyout && hresp == MMC_HRESP_OKAY)
      else $error("Slave stalled or answered an error.");

   // ------------------------------------------------------------
   // Reach of each edit, recorded fields and quiet cycles
   // ------------------------------------------------------------
   // Ones mark the bits an edit of the recorded index and port may touch, and the readable fields.
   logic [31:0]                         usedBits;
   logic [NUM_MASKS-1:0][NUM_PORTS-1:0] maskSel;
   logic [NUM_MASKS-1:0][NUM_PORTS-1:0] portSel;

   always_comb begin
      usedBits                             = '0;
      usedBits[MMC_MASK_LSB +: MMC_MASK_W] = '1;
      usedBits[MMC_PORT_LSB +: MMC_PORT_W] = '1;
      usedBits[MMC_CMD_LSB  +: MMC_CMD_W]  = '1;
      usedBits[MMC_FLAG_BIT]               = 1'h1;
      maskSel                              = '0;
      maskSel[maskIdxFf]                   = '1;
      portSel                              = '0;
      portSel[maskIdxFf][portIdxFf]        = 1'h1;
   end

   // Single-port edits touch nothing but the named bit of the named mask.
   chk_add_only_port: assert property (s_write(MMC_CMD_ADD)
         |=> ((maskFf ^ $past(maskFf)) & ~portSel) == '0)
      else $error("Add command touched another port or mask.");

   chk_del_only_port: assert property (s_write(MMC_CMD_DEL)
         |=> ((maskFf ^ $past(maskFf)) & ~portSel) == '0)
      else $error("Delete command touched another port or mask.");

   // Whole-mask edits touch only the selected row, whatever the port field holds.
   chk_clr_only_mask: assert property (s_write(MMC_CMD_CLR_ALL)
         |=> ((maskFf ^ $past(maskFf)) & ~maskSel) == '0)
      else $error("Delete-all touched another mask.");

   chk_set_only_mask: assert property (s_write(MMC_CMD_SET_ALL)
         |=> ((maskFf ^ $past(maskFf)) & ~maskSel) == '0)
      else $error("Add-all touched another mask.");

   // Without a mapped write nothing in the table may move.
   chk_idle_no_edit: assert property (!wrEn
         |=> $stable(maskFf))
      else $error("Mask table changed without a write.");

   chk_unmapped_no_edit: assert property (aphFf.wr && !aphFf.hit
         |=> $stable(maskFf) && $stable(cmdFf))
      else $error("Unmapped write changed the register.");

   chk_read_no_edit: assert property (aphFf.rd
         |=> $stable(maskFf)
             && $stable(cmdFf)
             && $stable(qMaskFf))
      else $error("A read changed the register.");

   chk_fields_recorded: assert property (wrEn
         |=> cmdFf == $past(wCmd)
             && maskIdxFf == $past(wIdx)
             && portIdxFf == $past(wPort))
      else $error("Write fields were not recorded.");

   chk_reserved_fields: assert property (wrEn
         && !(wCmd inside {MMC_CMD_QUERY, MMC_CMD_ADD, MMC_CMD_DEL, MMC_CMD_CLR_ALL, MMC_CMD_SET_ALL})
         |=> cmdFf == $past(wCmd))
      else $error("Reserved command code was not recorded.");

   chk_query_latched: assert property (s_write(MMC_CMD_QUERY)
         |=> qMaskFf == $past(wIdx)
             && qPortFf == $past(wPort))
      else $error("Query setup did not latch its target.");

   chk_query_held: assert property (wrEn && (wCmd != MMC_CMD_QUERY)
         |=> $stable(qMaskFf)
             && $stable(qPortFf))
      else $error("A non-query write moved the query target.");

   chk_flag_live: assert property (s_readBack
         |-> hrdata[MMC_FLAG_BIT] == maskFf[qMaskFf][qPortFf])
      else $error("Membership flag does not follow the table.");

   chk_spare_zero: assert property (s_readBack
         |-> (hrdata & ~usedBits) == '0)
      else $error("A spare bit read back non-zero.");

   chk_quiet_read: assert property (!(aphFf.rd && aphFf.hit)
         |-> hrdata == '0)
      else $error("Read data present outside a read data phase.");

   chk_capture_dir: assert property (take
         |=> aphFf.wr != aphFf.rd)
      else $error("Captured transfer has no single direction.");

   // Reset must leave every field and every mask empty before the first transfer.
   chk_reset_clears: assert property ($fell(rst)
         |-> maskFf == '0
             && cmdFf == '0
             && maskIdxFf == '0
             && portIdxFf == '0
             && qMaskFf == '0
             && qPortFf == '0)
      else $error("Reset left state behind.");

endmodule

// ==== design/mmc_pkg.sv ====
// Constants, field layout and bus carrier types for the multicast mask edit port.
// Assumes a single register clock and an AHB-Lite master with 32-bit data.
package mmc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [31:0] MMC_EDIT_OFFSET = 32'h0000_0080;
   localparam logic [31:0] MMC_EDIT_RESET  = 32'h0000_0000;

   // ------------------------------------------------------------
   // Field positions (LSB-zero numbering of the bus word)
   // ------------------------------------------------------------
   localparam int MMC_MASK_LSB = 16;
   localparam int MMC_MASK_W   = 3;
   localparam int MMC_PORT_LSB = 8;
   localparam int MMC_PORT_W   = 4;
   localparam int MMC_CMD_LSB  = 4;
   localparam int MMC_CMD_W    = 3;
   localparam int MMC_FLAG_BIT = 0;

   // ------------------------------------------------------------
   // Edit commands
   // ------------------------------------------------------------
   typedef enum logic [MMC_CMD_W-1:0] {
      MMC_CMD_QUERY   = 3'h0,
      MMC_CMD_ADD     = 3'h1,
      MMC_CMD_DEL     = 3'h2,
      MMC_CMD_CLR_ALL = 3'h4,
      MMC_CMD_SET_ALL = 3'h5
   } mmc_cmd_t;

   // ------------------------------------------------------------
   // AHB-Lite encodings
   // ------------------------------------------------------------
   localparam logic [1:0] MMC_HTRANS_NONSEQ = 2'h2;
   localparam logic       MMC_HRESP_OKAY    = 1'h0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic hit;
   } mmc_aphase_t;

   localparam mmc_aphase_t MMC_APHASE_IDLE = '{wr: 1'h0, rd: 1'h0, hit: 1'h0};

endpackage

// ==== verification/mmc_tb.sv ====
// Self-checking bench for the multicast mask edit port.
// Drives the AHB-Lite port itself; the one slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module testbench;
   import mmc_pkg::*;
   logic             clk       = 1'b0;
   logic             rst       = 1'b1;
   logic             hsel      = 1'b0;
   logic [31:0]      haddr     = 32'h0;
   logic [1:0]       htrans    = 2'h0;
   logic             hwrite    = 1'b0;
   logic [31:0]      hwdata    = 32'h0;
   logic             hready;
   logic [31:0]      hrdata;
   logic             hreadyout;
   logic             hresp;
   logic [7:0][15:0] maskTable;
   logic [7:0][15:0] expTable  = '0;
   logic [31:0]      lastWord  = 32'h0;
   logic [2:0]       qMask     = 3'h0;
   logic [3:0]       qPort     = 4'h0;
   int               failures  = 0;
   int               tests_run = 0;
   int               cycles    = 0;

   assign hready = hreadyout;
   always #4 clk = ~clk;

   mmc_mask_cfg i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .maskTable(maskTable));

   // ------------------------------------------------------------
   // Bus and comparison helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= addr;
      htrans <= MMC_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wdata;
      do @(posedge clk); while (hready !== 1'b1);
      rdata = hrdata;
      chk(hresp, MMC_HRESP_OKAY);
   endtask

   // One write, then the table and the readback word are judged against the bench's own model.
   task automatic edit(input logic [31:0] addr, input logic [2:0] m, input logic [3:0] p, input logic [2:0] c);
      logic [31:0] w;
      logic [31:0] r;
      w = 32'h0;
      w[18:16] = m;
      w[11:8] = p;
      w[6:4] = c;
      bus(addr, 1'b1, w, r);
      if (addr == MMC_EDIT_OFFSET) begin
         lastWord = w;
         case (c)
            3'h0: begin
               qMask = m;
               qPort = p;
            end
            3'h1: expTable[m][p] = 1'b1;
            3'h2: expTable[m][p] = 1'b0;
            3'h4: expTable[m] = 16'h0000;
            3'h5: expTable[m] = 16'hFFFF;
            default: ;
         endcase
      end
      @(negedge clk);
      chk(maskTable, expTable);
      bus(MMC_EDIT_OFFSET, 1'b0, 32'h0, r);
      chk(r, {lastWord[31:1], expTable[qMask][qPort]});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_reset;
      logic [31:0] r;
      bus(MMC_EDIT_OFFSET, 1'b0, 32'h0, r);
      chk(r, MMC_EDIT_RESET);
      chk(maskTable, '0);
   endtask

   task automatic s_single;
      edit(MMC_EDIT_OFFSET, 3'h3, 4'h5, MMC_CMD_ADD);
      edit(MMC_EDIT_OFFSET, 3'h3, 4'hF, MMC_CMD_ADD);
      edit(MMC_EDIT_OFFSET, 3'h7, 4'h0, MMC_CMD_ADD);
      edit(MMC_EDIT_OFFSET, 3'h3, 4'hF, MMC_CMD_QUERY);
      edit(MMC_EDIT_OFFSET, 3'h3, 4'h5, MMC_CMD_DEL);
      edit(MMC_EDIT_OFFSET, 3'h3, 4'h5, MMC_CMD_QUERY);
   endtask

   task automatic s_all;
      edit(MMC_EDIT_OFFSET, 3'h0, 4'h9, MMC_CMD_SET_ALL);
      edit(MMC_EDIT_OFFSET, 3'h0, 4'h2, MMC_CMD_QUERY);
      edit(MMC_EDIT_OFFSET, 3'h0, 4'h3, MMC_CMD_CLR_ALL);
      edit(MMC_EDIT_OFFSET, 3'h6, 4'hF, MMC_CMD_SET_ALL);
   endtask

   task automatic s_reserved;
      logic [2:0] rsv [3] = '{3'h3, 3'h6, 3'h7};
      foreach (rsv[i]) edit(MMC_EDIT_OFFSET, 3'h6, 4'h1, rsv[i]);
      edit(MMC_EDIT_OFFSET, 3'h7, 4'h0, 3'h3);
   endtask

   task automatic s_unmapped;
      logic [31:0] r;
      edit(32'h0000_0084, 3'h6, 4'h2, MMC_CMD_CLR_ALL);
      bus(32'h0000_0084, 1'b0, 32'h0, r);
      chk(r, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Thirty-two short transfers fit well inside this ceiling.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_single();
      s_all();
      s_reserved();
      s_unmapped();
      wrap_up();
   end
endmodule
